// ### hw/asfi_pkg.sv
package asfi_pkg;
    // ************************************************************
    // frame and control word layout
    // ************************************************************
    localparam int DATA_W = 12;
    localparam int CTRL_W = 12;
    localparam int FRAME_W = 16;
    localparam int CHAN_W = 2;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] LOAD_EDGE = 5'h0c;
    localparam logic [CNT_W-1:0] MUX_EDGE = 5'h0e;
    localparam logic [CNT_W-1:0] LAST_EDGE = 5'h10;
    localparam int CB_WRITE = 11;
    localparam int CB_SEQUENCER_CTRL_HI = 10;
    localparam int CB_ADD_HI = 7;
    localparam int CB_ADD_LO = 6;
    localparam int CB_SEQUENCER_CTRL_LO = 3;
    localparam int CB_RANGE = 1;
    localparam int CB_CODING = 0;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;
    // ************************************************************
    // register map
    // ************************************************************
    localparam int AW = 8;
    localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
    localparam logic [AW-1:0] ADDR_STATUS = 8'h04;
    localparam logic [AW-1:0] ADDR_LAST = 8'h08;
    localparam int ST_BUSY = 0;
    localparam int ST_UNDER = 1;
    localparam int ST_CHAN = 4;
    localparam int ST_FRAMES = 8;
    localparam int FRAMES_W = 8;

    typedef enum logic [1:0] {
        LS_IDLE = 2'b00,
        LS_FRAME = 2'b01,
        LS_DONE = 2'b10
    } asfi_link_state_type;

    // twos complement is straight binary with the msb turned over
    function automatic logic [DATA_W-1:0] asfi_code(
        input logic [DATA_W-1:0] raw, input logic twos);
        asfi_code = raw ^ {twos, 11'h000};
    endfunction

    // channel after cur: consecutive run 0..addr, or the address itself
    function automatic logic [CHAN_W-1:0] asfi_next_chan(
        input logic [CTRL_W-1:0] ctrl, input logic [CHAN_W-1:0] cur);
        logic [CHAN_W-1:0] addr;
        addr = ctrl[CB_ADD_HI:CB_ADD_LO];
        if (ctrl[CB_SEQUENCER_CTRL_HI] && ctrl[CB_SEQUENCER_CTRL_LO]) begin
            asfi_next_chan = (cur == addr) ? 2'h0 : cur + 2'h1;
        end else begin
            asfi_next_chan = addr;
        end
    endfunction
endpackage

// ### hw/asfi_stream_if.sv
`timescale 1ns/1ns
`default_nettype none
interface asfi_stream_if #(parameter int W = 12);
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src(output data, output valid, input ready);
    modport snk(input data, input valid, output ready);
endinterface
`default_nettype wire

// ### hw/asfi_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module asfi_pin_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] IDLE_VAL = '0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_sync
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } asfi_sync_type;
    asfi_sync_type s_r, s_nxt;

    // first stage feeds the second and nothing else
    always_comb begin
        s_nxt.s1 = pin_in;
        s_nxt.s2 = s_r.s1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= {IDLE_VAL, IDLE_VAL};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pin_sync = s_r.s2;
endmodule
`default_nettype wire

// ### hw/asfi_two_buf.sv
`timescale 1ns/1ns
`default_nettype none
module asfi_two_buf #(
    parameter int W = 12,
    parameter int DEPTH = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    asfi_stream_if.snk fill,
    asfi_stream_if.src drain
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
            $error("asfi_two_buf: DEPTH must be a power of two >= 2");
        end
    endgenerate

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [PW:0] cnt;
        logic not_full;
    } asfi_buf_type;
    asfi_buf_type s_r, s_nxt;

    logic push;
    logic pop;

    // ready is kept in a flop so the source never sees a comb path
    always_comb begin
        s_nxt = s_r;
        push = fill.valid && s_r.not_full;
        pop = drain.ready && (s_r.cnt != '0);
        if (push) begin
            s_nxt.mem[s_r.wr] = fill.data;
            s_nxt.wr = s_r.wr + 1'b1;
        end
        if (pop) begin
            s_nxt.rd = s_r.rd + 1'b1;
        end
        s_nxt.cnt = s_r.cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
        s_nxt.not_full = (s_nxt.cnt != DEPTH[PW:0]);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{mem: '0, wr: '0, rd: '0, cnt: '0, not_full: 1'b1};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign fill.ready = s_r.not_full;
    assign drain.valid = (s_r.cnt != '0);
    assign drain.data = s_r.mem[s_r.rd];
endmodule
`default_nettype wire

// ### hw/asfi_serial_frame.sv
// Overview of operation
// - shift clock moves the data and paces each conversion
// - control bits on the serial input are taken on shift clock falls
// - select falling starts a conversion and opens the frame
// - two-bit channel field picks one of four inputs for the mux
// - sequencer bits with address run consecutive channels in turn
// - one range bit sets the span for every channel
// - frame is two zeros, channel tag, twelve result bits msb first
// - coding bit picks straight binary or twos complement
// - output bits change on shift clock falling edges
// - sixteen clocks per frame, only first twelve bits load, msb first
// - first bit qualifies the write; zero leaves the register as is
// - mux moves to the next channel on the fourteenth fall
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module asfi_serial_frame #(
    parameter int BUF_DEPTH = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [asfi_pkg::AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    output logic dout,
    output logic dout_oe_n,
    input wire logic [asfi_pkg::DATA_W-1:0] conv_data,
    input wire logic conv_valid,
    output logic conv_ready,
    output logic [asfi_pkg::CHAN_W-1:0] mux_chan,
    output logic range_double
);
    import asfi_pkg::*;

    // ************************************************************
    // pin synchronisers and result buffer
    // ************************************************************
    logic [2:0] pins_s;
    logic cs_s;
    logic sclk_s;
    logic din_s;

    asfi_pin_sync #(.W(3), .IDLE_VAL(3'h6)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in({cs_n, sclk, din}),
        .pin_sync(pins_s)
    );
    assign cs_s = pins_s[2];
    assign sclk_s = pins_s[1];
    assign din_s = pins_s[0];

    asfi_stream_if #(.W(DATA_W)) conv_in ();
    asfi_stream_if #(.W(DATA_W)) conv_out ();
    assign conv_in.data = conv_data;
    assign conv_in.valid = conv_valid;
    assign conv_ready = conv_in.ready;

    // a stalled core waits here instead of dropping a result
    asfi_two_buf #(.W(DATA_W), .DEPTH(BUF_DEPTH)) u_buf (
        .pclk(pclk),
        .presetn(presetn),
        .fill(conv_in),
        .drain(conv_out)
    );

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        asfi_link_state_type st;
        logic [CTRL_W-1:0] ctrl;
        logic [CHAN_W-1:0] chan;
        logic [CNT_W-1:0] cnt;
        logic [CTRL_W-1:0] rx;
        logic [FRAME_W-1:0] tx;
        logic [FRAME_W-1:0] last;
        logic [FRAMES_W-1:0] frames;
        logic under;
        logic cs_d;
        logic sclk_d;
        logic dout;
        logic oe_n;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } asfi_top_type;
    asfi_top_type s_r, s_nxt;

    logic cs_fall;
    logic cs_rise;
    logic sclk_fall;
    logic apb_take;
    logic apb_wr_ctrl;
    logic [CTRL_W-1:0] rx_shift;
    logic mux_hit;
    logic [CNT_W-1:0] cnt_inc;
    logic [DATA_W-1:0] coded;

    assign cs_fall = s_r.cs_d && !cs_s;
    assign cs_rise = !s_r.cs_d && cs_s;
    assign sclk_fall = s_r.sclk_d && !sclk_s;
    assign apb_take = psel && penable && !s_r.pready;
    assign apb_wr_ctrl = apb_take && pwrite && (paddr == ADDR_CTRL);
    assign rx_shift = {s_r.rx[CTRL_W-2:0], din_s};
    assign cnt_inc = s_r.cnt + 5'h01;
    assign mux_hit = (s_r.st == LS_FRAME) && !cs_s && sclk_fall &&
        (cnt_inc == MUX_EDGE);
    assign coded = asfi_code(conv_out.data, s_r.ctrl[CB_CODING]);
    // the result is taken at the very edge that samples the input
    assign conv_out.ready = (s_r.st == LS_IDLE) && cs_fall;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.cs_d = cs_s;
        s_nxt.sclk_d = sclk_s;
        s_nxt.pready = 1'b0;
        s_nxt.pslverr = 1'b0;
        s_nxt.prdata = 32'h0000_0000;

        // register bus: answer one cycle into the access phase
        if (apb_take) begin
            s_nxt.pready = 1'b1;
            case (paddr)
                ADDR_CTRL: begin
                    if (pwrite) begin
                        s_nxt.ctrl = pwdata[CTRL_W-1:0];
                    end else begin
                        s_nxt.prdata = {20'h00000, s_r.ctrl};
                    end
                end
                ADDR_STATUS: begin
                    if (pwrite) begin
                        if (pwdata[ST_UNDER]) begin
                            s_nxt.under = 1'b0;
                        end
                    end else begin
                        s_nxt.prdata[ST_BUSY] = (s_r.st != LS_IDLE);
                        s_nxt.prdata[ST_UNDER] = s_r.under;
                        s_nxt.prdata[ST_CHAN +: CHAN_W] = s_r.chan;
                        s_nxt.prdata[ST_FRAMES +: FRAMES_W] = s_r.frames;
                    end
                end
                ADDR_LAST: begin
                    s_nxt.prdata = {16'h0000, s_r.last};
                    s_nxt.pslverr = pwrite;
                end
                default: begin
                    s_nxt.pslverr = 1'b1;
                end
            endcase
        end

        case (s_r.st)
            LS_IDLE: begin
                s_nxt.oe_n = 1'b1;
                s_nxt.dout = 1'b0;
                if (cs_fall) begin
                    // conversion of the current mux channel begins here
                    s_nxt.st = LS_FRAME;
                    s_nxt.cnt = '0;
                    s_nxt.oe_n = 1'b0;
                    s_nxt.tx = {2'b00, s_r.chan, coded};
                    if (!conv_out.valid) begin
                        s_nxt.tx[DATA_W-1:0] = '0;
                        s_nxt.under = 1'b1;
                    end
                    s_nxt.last = s_nxt.tx;
                    s_nxt.dout = 1'b0;
                end
            end
            LS_FRAME, LS_DONE: begin
                if (cs_s) begin
                    s_nxt.st = LS_IDLE;
                    s_nxt.oe_n = 1'b1;
                    s_nxt.dout = 1'b0;
                    if (s_r.st == LS_DONE) begin
                        s_nxt.frames = s_r.frames + 8'h01;
                    end
                end else if (sclk_fall && s_r.st == LS_FRAME) begin
                    // every step is paced by the shift clock alone
                    s_nxt.cnt = cnt_inc;
                    s_nxt.tx = {s_r.tx[FRAME_W-2:0], 1'b0};
                    s_nxt.dout = s_r.tx[FRAME_W-2];
                    if (s_r.cnt < LOAD_EDGE) begin
                        s_nxt.rx = rx_shift;
                    end
                    if (cnt_inc == LOAD_EDGE && s_r.rx[CTRL_W-2]) begin
                        s_nxt.ctrl = rx_shift;
                    end
                    if (mux_hit) begin
                        s_nxt.chan = asfi_next_chan(s_nxt.ctrl,
                            s_r.chan);
                    end
                    if (cnt_inc == LAST_EDGE) begin
                        s_nxt.st = LS_DONE;
                    end
                end
            end
            default: begin
                s_nxt.st = LS_IDLE;
            end
        endcase
        // under-run that hits during its clear still shows
        if (s_r.st == LS_IDLE && cs_fall && !conv_out.valid) begin
            s_nxt.under = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{st: LS_IDLE, ctrl: CTRL_RESET, chan: '0, cnt: '0,
                rx: '0, tx: '0, last: '0, frames: '0, under: 1'b0,
                cs_d: 1'b1, sclk_d: 1'b1, dout: 1'b0, oe_n: 1'b1,
                prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign dout = s_r.dout;
    assign dout_oe_n = s_r.oe_n;
    assign mux_chan = s_r.chan;
    assign range_double = s_r.ctrl[CB_RANGE];

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_frame_open: assert property (
        (s_r.st == LS_IDLE && cs_fall) |=>
            (s_r.st == LS_FRAME && !dout_oe_n && s_r.cnt == '0))
        else $error("frame did not open on select fall");

    a_out_release: assert property (
        (s_r.st != LS_IDLE && cs_s) |=> dout_oe_n [*2])
        else $error("output driven after select rose");

    a_frame_head: assert property (
        (s_r.st == LS_IDLE && cs_fall) |=>
            (s_r.tx[15:14] == 2'b00 && !dout &&
            s_r.tx[13:12] == $past(s_r.chan)))
        else $error("frame head is not zeros and channel tag");

    a_ctrl_load: assert property (
        (sclk_fall && !cs_s && s_r.st == LS_FRAME &&
        cnt_inc == LOAD_EDGE && s_r.rx[10]) |=>
            (s_r.ctrl == $past(rx_shift)))
        else $error("control word not loaded on twelfth fall");

    a_ctrl_keep: assert property (
        (sclk_fall && !cs_s && s_r.st == LS_FRAME &&
        cnt_inc == LOAD_EDGE && !s_r.rx[10] && !apb_wr_ctrl) |=>
            $stable(s_r.ctrl))
        else $error("control word changed without write bit");

    a_mux_edge: assert property (
        $changed(s_r.chan) |-> $past(mux_hit))
        else $error("mux channel moved away from fourteenth fall");

    a_seq_wrap: assert property (
        (mux_hit && s_nxt.ctrl[CB_SEQUENCER_CTRL_HI] && s_nxt.ctrl[CB_SEQUENCER_CTRL_LO] &&
        s_r.chan == s_nxt.ctrl[CB_ADD_HI:CB_ADD_LO]) |=>
            (mux_chan == 2'h0))
        else $error("sequence did not wrap to channel zero");

    a_chan_pick: assert property (
        (mux_hit && !(s_nxt.ctrl[CB_SEQUENCER_CTRL_HI] && s_nxt.ctrl[CB_SEQUENCER_CTRL_LO])) |=>
            (mux_chan == $past(s_nxt.ctrl[CB_ADD_HI:CB_ADD_LO])))
        else $error("mux channel differs from address field");

    a_dout_edge: assert property (
        ($changed(dout) && !dout_oe_n && $past(!dout_oe_n)) |->
            $past(sclk_fall))
        else $error("output bit moved away from a shift clock fall");

    a_coding: assert property (
        (s_r.st == LS_IDLE && cs_fall && conv_out.valid) |=>
            (s_r.tx[11] == ($past(conv_out.data[11]) ^
            $past(s_r.ctrl[CB_CODING]))))
        else $error("result msb not coded as selected");

    a_frame_len: assert property (
        s_r.cnt <= LAST_EDGE)
        else $error("frame ran past sixteen falls");

    a_range_span: assert property (
        (sclk_fall && !cs_s && s_r.st == LS_FRAME &&
        cnt_inc == LOAD_EDGE && s_r.rx[10]) |=>
            (range_double == $past(rx_shift[CB_RANGE])))
        else $error("range output differs from loaded range bit");
endmodule
`default_nettype wire

// ### test/asfi_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// host side of the serial link
// ************************************************************
module asfi_host_model (
    input wire logic pclk,
    output logic cs_n,
    output logic sclk,
    output logic din,
    input wire logic dout,
    input wire logic dout_oe_n
);
    // half of the 160 ns shift clock, in pclk cycles
    localparam int HALF = 4;
    // no pull on the line: a released pin shows the inverse
    wire logic dline = dout_oe_n ? ~dout : dout;

    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        din = 1'b0;
    end

    // clock stands high between frames
    task automatic frame(input logic [15:0] w, output logic [15:0] q);
        @(posedge pclk);
        cs_n <= 1'b0;
        repeat (2 * HALF) @(posedge pclk);
        for (int i = 15; i >= 0; i--) begin
            din <= w[i];
            repeat (HALF) @(posedge pclk);
            // sampled just before the fall, away from the change
            q[i] = dline;
            sclk <= 1'b0;
            repeat (HALF) @(posedge pclk);
            sclk <= 1'b1;
        end
        cs_n <= 1'b1;
        din <= ~din;
        repeat (10) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// ### test/adc_serial_frame_interface_tb.sv
`timescale 1ns/1ns
`default_nettype none
module adc_serial_frame_interface_tb;
    import asfi_pkg::*;
    typedef struct packed {
        logic [15:0] din_word;
        logic [11:0] raw;
        logic [15:0] frame;
        logic [1:0] chan;
        logic rng;
    } asfi_row_type;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [AW-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic cs_n, sclk, din, dout, dout_oe_n, conv_valid, conv_ready;
    logic [DATA_W-1:0] conv_data;
    logic [CHAN_W-1:0] mux_chan;
    logic range_double, err;
    logic [15:0] q;
    int fails, checks_done;

    // ************************************************************
    // cases: control word in, raw result, frame out, channel after
    // ************************************************************
    asfi_row_type rows [5] = '{
        '{16'h8800, 12'h123, 16'h0123, 2'h2, 1'b0},
        '{16'h0000, 12'h456, 16'h2456, 2'h2, 1'b0},
        '{16'hccb0, 12'h789, 16'h2789, 2'h3, 1'b1},
        '{16'h0000, 12'h800, 16'h3000, 2'h0, 1'b1},
        '{16'h0000, 12'h7ff, 16'h0fff, 2'h1, 1'b1}
    };

    asfi_serial_frame dut_u (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cs_n(cs_n), .sclk(sclk), .din(din),
        .dout(dout), .dout_oe_n(dout_oe_n), .conv_data(conv_data),
        .conv_valid(conv_valid), .conv_ready(conv_ready),
        .mux_chan(mux_chan), .range_double(range_double));

    asfi_host_model host_u (.pclk(pclk), .cs_n(cs_n), .sclk(sclk), .din(din),
        .dout(dout), .dout_oe_n(dout_oe_n));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [AW-1:0] a,
        input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            fails++;
            tally_and_finish();
        end
    endtask

    // valid held until the buffer takes the word
    task automatic push(input logic [DATA_W-1:0] v);
        int n;
        @(posedge pclk);
        conv_data <= v;
        conv_valid <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (conv_ready !== 1'b1 && n < 20);
        conv_valid <= 1'b0;
        if (n >= 20) begin
            fails++;
            tally_and_finish();
        end
    endtask

    initial begin
        repeat (100000) @(posedge pclk);
        fails++;
        tally_and_finish();
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        fails = 0;
        checks_done = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        conv_data = '0;
        conv_valid = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        chk("oe_n at reset", dout_oe_n, 1'b1);
        chk("mux at reset", mux_chan, 2'h0);
        chk("range at reset", range_double, 1'b0);
        // two words fill the buffer while no frame drains it
        push(rows[0].raw);
        push(rows[1].raw);
        @(posedge pclk);
        chk("buffer full", conv_ready, 1'b0);
        for (int i = 0; i < 5; i++) begin
            host_u.frame(rows[i].din_word, q);
            chk("frame", q, rows[i].frame);
            chk("mux chan", mux_chan, rows[i].chan);
            chk("range", range_double, rows[i].rng);
            chk("oe_n idle", dout_oe_n, 1'b1);
            if (i < 3) begin
                push(rows[i + 2].raw);
            end
            $display("row %0d done", i);
        end
        // empty buffer: data bits zero, under flag raised
        host_u.frame(16'h0000, q);
        chk("underrun frame", q, 16'h1000);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("status", rd, 32'h0000_0622);
        apb(1'b1, ADDR_STATUS, 32'h2);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("status cleared", rd, 32'h0000_0620);
        apb(1'b0, ADDR_LAST, 32'h0);
        chk("last frame", rd, 32'h0000_1000);
        apb(1'b1, ADDR_LAST, 32'h5);
        chk("last write err", err, 1'b1);
        apb(1'b0, 8'h0c, 32'h0);
        chk("unmapped err", err, 1'b1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl read", rd, 32'h0000_0ccb);
        apb(1'b1, ADDR_CTRL, 32'h0);
        @(posedge pclk);
        chk("range off", range_double, 1'b0);
        $display("register tests done");
        // second reset in mid-run
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("mux after reset", mux_chan, 2'h0);
        chk("oe_n after reset", dout_oe_n, 1'b1);
        presetn <= 1'b1;
        // first frame after reset: tag zero, empty buffer, count restarts
        repeat (4) @(posedge pclk);
        host_u.frame(16'h0000, q);
        chk("frame after reset", q, 16'h0000);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("status after reset", rd, 32'h0000_0102);
        $display("reset test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
